// *** hdl/msd_memory_space_decoder.sv ***
// Memory space decoder: routes instruction fetches and data transfers to their targets.
// Assumes requests come from core logic on sys_clk; the targets answer on their own.
//
// Contract
// - Address space is 16 Mbytes linear, 256 segments of 64 Kbytes.
// - Each segment holds four 16 Kbyte pages from the next two bits.
// - Every location takes byte and word accesses; width comes with the request.
// - Internal data memories and both register areas sit in segment 0.
// - Instruction fetches go only through the program fetch unit to program memories; the code also accepts fetches from external space.
// - Data transfers go through the data transfer unit to RAMs and peripherals.
// - Cross-unit traffic uses the system bus, both directions concurrently.
// - Program RAM is up to 64 Kbytes, behind the program fetch unit.
// - Writes into the protected low part of program RAM are blocked.
// - Data RAM gives 16 Kbytes on its own interface.
// - Dual-port RAM gives 2 Kbytes for variables, stack and register banks.
// - Sixteen word registers in dual-port RAM; lower eight split into byte halves.
// - Bit operations allowed on top 256 dual-port bytes and any register.
// - Standby RAM of 1 Kbyte on its own retained interface.
`timescale 1ns/1ps
module msd_memory_space_decoder
  import msd_pkg::*;
#(
  parameter int PRAM_KB = MSD_PRAM_KB_MAX
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [MSD_ADDR_W-1:0] fetch_addr,
  input wire logic data_req,
  input wire logic [MSD_ADDR_W-1:0] data_addr,
  input wire logic data_write,
  input wire logic data_word,
  input wire logic data_bit_op,
  input wire logic data_reg,
  input wire logic [MSD_REG_IDX_W-1:0] reg_index,
  input wire logic [MSD_ADDR_W-1:0] reg_base,
  input wire logic prot_enable,
  input wire logic [MSD_PROT_W-1:0] prot_limit,
  output logic fetch_valid,
  output msd_target_type fetch_target,
  output logic [MSD_OFS_W-1:0] fetch_offset,
  output logic fetch_sysbus,
  output logic fetch_error,
  output logic data_valid,
  output msd_target_type data_target,
  output logic [MSD_OFS_W-1:0] data_offset,
  output logic [MSD_SEG_W-1:0] data_segment,
  output logic [MSD_PAGE_W-1:0] data_page,
  output logic [1:0] data_lanes,
  output logic data_store,
  output logic data_sysbus,
  output logic data_bit_ok,
  output logic data_error
);

  // Program RAM never exceeds one segment, so bigger sizes cannot be decoded.
  if (PRAM_KB < 1 || PRAM_KB > MSD_PRAM_KB_MAX) begin : g_bad_size
    $error("PRAM_KB must lie between 1 and 64");
  end

  // General register address: word register n at base+2n, byte k at base+2(k/2)+k[0].
  // Word index covers all sixteen, byte index covers the lower eight word registers.
  wire [MSD_ADDR_W-1:0] reg_word_addr = reg_base + {19'h00000, reg_index, 1'b0};
  wire [MSD_ADDR_W-1:0] reg_byte_addr = reg_base + {20'h00000, reg_index[3:1], 1'b0} +
                                        {23'h000000, reg_index[0]};
  wire [MSD_ADDR_W-1:0] eff_addr = !data_reg ? data_addr :
                                   (data_word ? reg_word_addr : reg_byte_addr);

  // Both ports decode in parallel, so a fetch never waits on a data transfer.
  msd_target_type f_target;
  msd_target_type d_target;
  logic [MSD_OFS_W-1:0] f_offset;
  logic [MSD_OFS_W-1:0] d_offset;
  logic d_bit_area;

  msd_region_decode #(
    .PRAM_KB(PRAM_KB)
  ) u_fetch_decode (
    .addr(fetch_addr),
    .target(f_target),
    .offset(f_offset),
    .bit_area()
  );

  msd_region_decode #(
    .PRAM_KB(PRAM_KB)
  ) u_data_decode (
    .addr(eff_addr),
    .target(d_target),
    .offset(d_offset),
    .bit_area(d_bit_area)
  );

  // Fetch checks: only program memories and external space answer fetches, and fetches are word wide.
  wire f_prog = f_target == MSD_T_FLASH || f_target == MSD_T_PROGRAM_RAM ||
                f_target == MSD_T_EXTERNAL;
  wire f_misalign = fetch_addr[0];
  wire f_bad = !f_prog || f_misalign;
  wire f_via_bus = f_target == MSD_T_EXTERNAL;

  // Data checks; a register access must land in dual-port RAM.
  wire d_misalign = data_word && eff_addr[0];
  wire d_unmapped = d_target == MSD_T_NONE;
  wire d_reg_out = data_reg && d_target != MSD_T_DUAL_PORT_RAM;
  wire d_flash_wr = data_write && d_target == MSD_T_FLASH;
  wire d_prot_hit = prot_enable && data_write && d_target == MSD_T_PROGRAM_RAM &&
                    d_offset[MSD_PROT_W-1:0] < prot_limit;
  wire d_bit_allow = d_bit_area || (data_reg && d_target == MSD_T_DUAL_PORT_RAM);
  wire d_bit_bad = data_bit_op && !d_bit_allow;
  wire d_bad = d_misalign || d_unmapped || d_reg_out || d_flash_wr || d_prot_hit ||
               d_bit_bad;

  // Program memories, local bus and external space sit across the system bus.
  wire d_via_bus = d_target == MSD_T_FLASH || d_target == MSD_T_PROGRAM_RAM ||
                   d_target == MSD_T_LOCAL_BUS || d_target == MSD_T_EXTERNAL;

  // Byte lanes: a word drives both, a byte picks its lane from address bit 0.
  wire [1:0] d_lanes = data_word ? 2'h3 : (eff_addr[0] ? 2'h2 : 2'h1);

  // Next values; a refused request still answers, with no target and the error flag.
  wire next_fetch_valid = fetch_req;
  wire msd_target_type next_fetch_target = (fetch_req && !f_bad) ? f_target : MSD_T_NONE;
  wire [MSD_OFS_W-1:0] next_fetch_offset = (fetch_req && !f_bad) ? f_offset : '0;
  wire next_fetch_sysbus = fetch_req && !f_bad && f_via_bus;
  wire next_fetch_error = fetch_req && f_bad;
  wire d_ok = data_req && !d_bad;
  wire msd_target_type next_data_target = d_ok ? d_target : MSD_T_NONE;
  wire [MSD_OFS_W-1:0] next_data_offset = d_ok ? d_offset : '0;

  // Fetch port registers: one answer per request, one cycle after it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_valid <= 1'b0;
      fetch_target <= MSD_T_NONE;
      fetch_offset <= '0;
      fetch_sysbus <= 1'b0;
      fetch_error <= 1'b0;
    end else begin
      fetch_valid <= next_fetch_valid;
      fetch_target <= next_fetch_target;
      fetch_offset <= next_fetch_offset;
      fetch_sysbus <= next_fetch_sysbus;
      fetch_error <= next_fetch_error;
    end
  end

  // Data port registers; segment and page reflect the decoded address of a request and are zero when no request is made.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_valid <= 1'b0;
      data_target <= MSD_T_NONE;
      data_offset <= '0;
      data_segment <= '0;
      data_page <= '0;
      data_lanes <= '0;
      data_store <= 1'b0;
      data_sysbus <= 1'b0;
      data_bit_ok <= 1'b0;
      data_error <= 1'b0;
    end else begin
      data_valid <= data_req;
      data_target <= next_data_target;
      data_offset <= next_data_offset;
      data_segment <= data_req ? eff_addr[MSD_ADDR_W-1:MSD_SEG_LSB] : '0;
      data_page <= data_req ? eff_addr[MSD_SEG_LSB-1:MSD_PAGE_LSB] : '0;
      data_lanes <= d_ok ? d_lanes : 2'h0;
      data_store <= d_ok && data_write;
      data_sysbus <= d_ok && d_via_bus;
      data_bit_ok <= d_ok && data_bit_op;
      data_error <= data_req && d_bad;
    end
  end

endmodule

// *** include/msd_pkg.sv ***
// Constants and types shared by the memory space decoder.
// Assumes a 24-bit byte address from the core and single-clock operation.
package msd_pkg;

  // Address layout: 8 segment bits over 16 offset bits, page in the top two offset bits.
  localparam int MSD_ADDR_W = 24;
  localparam int MSD_SEG_LSB = 16;
  localparam int MSD_SEG_W = 8;
  localparam int MSD_PAGE_LSB = 14;
  localparam int MSD_PAGE_W = 2;
  localparam int MSD_OFS_W = 20;
  localparam int MSD_REG_IDX_W = 4;
  localparam int MSD_PROT_W = 16;

  // System segment areas.
  localparam logic [23:0] MSD_DRAM_BASE = 24'h00a000;
  localparam logic [23:0] MSD_DRAM_LAST = 24'h00dfff;
  localparam logic [23:0] MSD_STANDBY_RAM_BASE = 24'h00e000;
  localparam logic [23:0] MSD_STANDBY_RAM_LAST = 24'h00e3ff;
  localparam logic [23:0] MSD_EXT_SPECIAL_REG_BASE = 24'h00f000;
  localparam logic [23:0] MSD_EXT_SPECIAL_REG_LAST = 24'h00f1ff;
  localparam logic [23:0] MSD_DUAL_PORT_RAM_BASE = 24'h00f600;
  localparam logic [23:0] MSD_DUAL_PORT_RAM_LAST = 24'h00fdff;
  localparam logic [23:0] MSD_DUAL_PORT_RAM_BIT_BASE = 24'h00fd00;
  localparam logic [23:0] MSD_SPECIAL_REG_BASE = 24'h00fe00;
  localparam logic [23:0] MSD_SPECIAL_REG_LAST = 24'h00ffff;

  // Segment ranges outside the system segment.
  localparam logic [7:0] MSD_EXT_SEG_FIRST = 8'h01;
  localparam logic [7:0] MSD_EXT_SEG_LAST = 8'h1f;
  localparam logic [7:0] MSD_LXB_SEG = 8'h20;
  localparam logic [7:0] MSD_FLASH_SEG_FIRST = 8'hc0;
  localparam logic [7:0] MSD_FLASH_SEG_LAST = 8'hcb;
  localparam logic [7:0] MSD_PRAM_SEG = 8'he0;
  localparam int MSD_PRAM_KB_MAX = 64;

  typedef enum logic [3:0] {
    MSD_T_NONE,
    MSD_T_FLASH,
    MSD_T_PROGRAM_RAM,
    MSD_T_DATA_RAM,
    MSD_T_DUAL_PORT_RAM,
    MSD_T_SPECIAL_REG,
    MSD_T_EXT_SPECIAL_REG,
    MSD_T_STANDBY_RAM,
    MSD_T_LOCAL_BUS,
    MSD_T_EXTERNAL
  } msd_target_type;

endpackage

// *** hdl/msd_region_decode.sv ***
// Combinational region decoder: one byte address in, target and local offset out.
// Assumes the caller registers the results; used once per request port.
`timescale 1ns/1ps
module msd_region_decode
  import msd_pkg::*;
#(
  parameter int PRAM_KB = MSD_PRAM_KB_MAX
) (
  input wire logic [MSD_ADDR_W-1:0] addr,
  output msd_target_type target,
  output logic [MSD_OFS_W-1:0] offset,
  output logic bit_area
);

  // Segment split and area hits; segment 0 holds every on-chip data area.
  wire [MSD_SEG_W-1:0] seg = addr[MSD_ADDR_W-1:MSD_SEG_LSB];
  wire [MSD_SEG_W-1:0] flash_idx = seg - MSD_FLASH_SEG_FIRST;
  wire [15:0] low = addr[15:0];
  wire pram_fit = {16'h0000, low} < 32'(PRAM_KB * 1024);
  wire hit_dram = addr >= MSD_DRAM_BASE && addr <= MSD_DRAM_LAST;
  wire hit_standby = addr >= MSD_STANDBY_RAM_BASE && addr <= MSD_STANDBY_RAM_LAST;
  wire hit_ext_regs = addr >= MSD_EXT_SPECIAL_REG_BASE && addr <= MSD_EXT_SPECIAL_REG_LAST;
  wire hit_dual_port = addr >= MSD_DUAL_PORT_RAM_BASE && addr <= MSD_DUAL_PORT_RAM_LAST;
  wire hit_regs = addr >= MSD_SPECIAL_REG_BASE && addr <= MSD_SPECIAL_REG_LAST;
  wire hit_ext = seg >= MSD_EXT_SEG_FIRST && seg <= MSD_EXT_SEG_LAST;
  wire hit_lxb = seg == MSD_LXB_SEG;
  wire hit_flash = seg >= MSD_FLASH_SEG_FIRST && seg <= MSD_FLASH_SEG_LAST;
  wire hit_pram = seg == MSD_PRAM_SEG && pram_fit;

  // Priority chain; areas never overlap so the order only documents intent.
  always_comb begin
    target = MSD_T_NONE;
    offset = '0;
    if (hit_dram) begin
      target = MSD_T_DATA_RAM;
      offset = MSD_OFS_W'(addr - MSD_DRAM_BASE);
    end else if (hit_standby) begin
      target = MSD_T_STANDBY_RAM;
      offset = MSD_OFS_W'(addr - MSD_STANDBY_RAM_BASE);
    end else if (hit_ext_regs) begin
      target = MSD_T_EXT_SPECIAL_REG;
      offset = MSD_OFS_W'(addr - MSD_EXT_SPECIAL_REG_BASE);
    end else if (hit_dual_port) begin
      target = MSD_T_DUAL_PORT_RAM;
      offset = MSD_OFS_W'(addr - MSD_DUAL_PORT_RAM_BASE);
    end else if (hit_regs) begin
      target = MSD_T_SPECIAL_REG;
      offset = MSD_OFS_W'(addr - MSD_SPECIAL_REG_BASE);
    end else if (hit_ext) begin
      target = MSD_T_EXTERNAL;
      offset = addr[MSD_OFS_W-1:0];
    end else if (hit_lxb) begin
      target = MSD_T_LOCAL_BUS;
      offset = {4'h0, low};
    end else if (hit_flash) begin
      target = MSD_T_FLASH;
      offset = {flash_idx[3:0], low};
    end else if (hit_pram) begin
      target = MSD_T_PROGRAM_RAM;
      offset = {4'h0, low};
    end
  end

  // Directly bit-addressable: top 256 bytes of dual-port RAM and both register areas.
  assign bit_area = (addr >= MSD_DUAL_PORT_RAM_BIT_BASE && addr <= MSD_DUAL_PORT_RAM_LAST) ||
                    hit_regs || hit_ext_regs;

endmodule

// *** verif/msd_memory_space_decoder_chk.sv ***
// Checker for answer timing and refusals of the memory space decoder.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
module msd_chk
  import msd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [MSD_ADDR_W-1:0] fetch_addr,
  input wire logic data_req,
  input wire logic [MSD_ADDR_W-1:0] data_addr,
  input wire logic data_write,
  input wire logic data_word,
  input wire logic data_bit_op,
  input wire logic data_reg,
  input wire logic prot_enable,
  input wire logic [MSD_PROT_W-1:0] prot_limit,
  input wire logic fetch_valid,
  input wire msd_target_type fetch_target,
  input wire logic fetch_error,
  input wire logic data_valid,
  input wire msd_target_type data_target,
  input wire logic [MSD_SEG_W-1:0] data_segment,
  input wire logic [MSD_PAGE_W-1:0] data_page,
  input wire logic [1:0] data_lanes,
  input wire logic data_store,
  input wire logic data_sysbus,
  input wire logic data_bit_ok,
  input wire logic data_error
);
  // Segment and page bits of a request, held for comparison one cycle on.
  logic [9:0] sp_in;
  assign sp_in = data_addr[23:14];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Each property except sys_data_a ties an answer to the request one edge earlier.
  fetch_answer_a: assert property (fetch_req |=> fetch_valid)
    else $error("fetch not answered");
  data_idle_a: assert property (!data_req |=>
    !data_valid && data_lanes == 2'b00 && !data_store) else $error("data answer without request");
  fetch_align_a: assert property (fetch_req && fetch_addr[0] |=>
    fetch_error && fetch_target == MSD_T_NONE) else $error("odd fetch accepted");
  word_align_a: assert property (data_req && data_word && !data_reg && data_addr[0] |=>
    data_error && data_lanes == 2'b00) else $error("odd word accepted");
  prot_block_a: assert property (data_req && data_write && !data_reg && prot_enable
    && data_addr[23:16] == MSD_PRAM_SEG && data_addr[15:0] < prot_limit
    |=> data_error && !data_store) else $error("protected write accepted");
  seg_page_a: assert property (data_req && !data_reg |=>
    {data_segment, data_page} == $past(sp_in)) else $error("segment or page wrong");
  sys_data_a: assert property (data_valid && !data_error && data_target inside
    {MSD_T_DATA_RAM, MSD_T_DUAL_PORT_RAM, MSD_T_SPECIAL_REG, MSD_T_STANDBY_RAM}
    |-> data_segment == 8'h00 && !data_sysbus) else $error("internal area misplaced");
  bit_area_a: assert property (data_req && data_bit_op && !data_reg && !data_word
    && data_addr[23:8] == 16'h00fd |=> data_bit_ok) else $error("bit area refused");
endmodule
bind msd_memory_space_decoder msd_chk msd_chk_i (.sys_clk, .rst, .fetch_req, .fetch_addr,
  .data_req, .data_addr, .data_write, .data_word, .data_bit_op, .data_reg, .prot_enable,
  .prot_limit, .fetch_valid, .fetch_target, .fetch_error, .data_valid, .data_target,
  .data_segment, .data_page, .data_lanes, .data_store, .data_sysbus, .data_bit_ok, .data_error);

// *** verif/msd_target_model.sv ***
// Far-side program RAM stand-in that counts the stores reaching it.
// Assumes decoder answers are settled at each rising clock edge.
`timescale 1ns/1ps
module msd_target_model
  import msd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic data_valid,
  input wire logic data_store,
  input wire msd_target_type data_target,
  output logic [15:0] pram_stores
);
  // Only accepted stores land, so a refused write leaves the count alone.
  initial pram_stores = 16'h0000;
  always @(posedge sys_clk) begin
    if (data_valid && data_store && data_target == MSD_T_PROGRAM_RAM) begin
      pram_stores <= pram_stores + 16'h0001;
    end
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the memory space decoder: corners, then random requests.
// Assumes every request is answered exactly one clock later.
`timescale 1ns/1ps
module testbench;
  import msd_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, fetch_req = 1'b0, data_req = 1'b0, data_write = 1'b0;
  logic data_word = 1'b0, data_bit_op = 1'b0, data_reg = 1'b0, prot_enable = 1'b0;
  logic [23:0] fetch_addr = 24'h000000, data_addr = 24'h000000, reg_base = 24'h000000;
  logic [3:0] reg_index = 4'h0;
  logic [15:0] prot_limit = 16'h0000, pram_stores, exp_st = 16'h0000;
  logic fetch_valid, fetch_sysbus, fetch_error, data_valid, data_store, data_sysbus;
  logic data_bit_ok, data_error;
  msd_target_type fetch_target, data_target;
  logic [19:0] fetch_offset, data_offset;
  logic [7:0] data_segment;
  logic [1:0] data_page, data_lanes;
  logic [31:0] pf = 0, pd = 0, r;
  logic [19:0] pfo = 20'h00000, pdo = 20'h00000;
  int mismatches = 0, cmp_count = 0, ticks = 0;
  integer seed = 32'h2492;
  logic [7:0] segs [6] = '{8'h00, 8'h05, 8'h20, 8'hc3, 8'he0, 8'h77};
  logic [23:0] rbs [3] = '{MSD_DUAL_PORT_RAM_BASE, 24'h00fde8, MSD_DRAM_BASE};
  msd_memory_space_decoder msd_memory_space_decoder_i (.sys_clk, .rst, .fetch_req,
    .fetch_addr, .data_req, .data_addr, .data_write, .data_word, .data_bit_op, .data_reg,
    .reg_index, .reg_base, .prot_enable, .prot_limit, .fetch_valid, .fetch_target,
    .fetch_offset, .fetch_sysbus, .fetch_error, .data_valid, .data_target, .data_offset,
    .data_segment, .data_page, .data_lanes, .data_store, .data_sysbus, .data_bit_ok,
    .data_error);
  msd_target_model msd_target_model_i (.sys_clk, .data_valid, .data_store, .data_target,
    .pram_stores);
  always #2.5 sys_clk = ~sys_clk;
  // About 1500 requests are issued, so 5000 cycles means a hang.
  always @(posedge sys_clk) begin
    ticks++;
    if (ticks == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Reference map of the address space.
  function automatic msd_target_type tgt(input logic [23:0] a);
    if (a inside {[MSD_DRAM_BASE:MSD_DRAM_LAST]}) return MSD_T_DATA_RAM;
    if (a inside {[MSD_STANDBY_RAM_BASE:MSD_STANDBY_RAM_LAST]}) return MSD_T_STANDBY_RAM;
    if (a inside {[MSD_EXT_SPECIAL_REG_BASE:MSD_EXT_SPECIAL_REG_LAST]})
      return MSD_T_EXT_SPECIAL_REG;
    if (a inside {[MSD_DUAL_PORT_RAM_BASE:MSD_DUAL_PORT_RAM_LAST]}) return MSD_T_DUAL_PORT_RAM;
    if (a inside {[MSD_SPECIAL_REG_BASE:MSD_SPECIAL_REG_LAST]}) return MSD_T_SPECIAL_REG;
    if (a[23:16] inside {[MSD_EXT_SEG_FIRST:MSD_EXT_SEG_LAST]}) return MSD_T_EXTERNAL;
    if (a[23:16] == MSD_LXB_SEG) return MSD_T_LOCAL_BUS;
    if (a[23:16] inside {[MSD_FLASH_SEG_FIRST:MSD_FLASH_SEG_LAST]}) return MSD_T_FLASH;
    if (a[23:16] == MSD_PRAM_SEG) return MSD_T_PROGRAM_RAM;
    return MSD_T_NONE;
  endfunction
  // Expected offset inside a target: distance from its area base in the map, low 20 address bits for external space.
  function automatic logic [19:0] ofs(input logic [23:0] a, input msd_target_type t);
    case (t)
      MSD_T_DATA_RAM: return 20'(a - MSD_DRAM_BASE);
      MSD_T_STANDBY_RAM: return 20'(a - MSD_STANDBY_RAM_BASE);
      MSD_T_EXT_SPECIAL_REG: return 20'(a - MSD_EXT_SPECIAL_REG_BASE);
      MSD_T_DUAL_PORT_RAM: return 20'(a - MSD_DUAL_PORT_RAM_BASE);
      MSD_T_SPECIAL_REG: return 20'(a - MSD_SPECIAL_REG_BASE);
      MSD_T_EXTERNAL: return a[19:0];
      MSD_T_FLASH: return {4'(a[23:16] - MSD_FLASH_SEG_FIRST), a[15:0]};
      MSD_T_NONE: return 20'h00000;
      default: return {4'h0, a[15:0]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One cycle: launch a request pair, check the answers to the previous one.
  // Mode m is {write, word, bit op, register}.
  task automatic go(input logic fr, input logic [23:0] fa, input logic dr,
      input logic [23:0] da, input logic [3:0] m, input logic [3:0] ri,
      input logic [23:0] rb, input logic pe, input logic [15:0] pl);
    logic [23:0] ea;
    msd_target_type ft, t;
    logic fe, e;
    ea = m[0] ? rb + (m[2] ? {19'h0, ri, 1'b0} : {20'h0, ri}) : da;
    ft = tgt(fa);
    t = tgt(ea);
    fe = fa[0] || !(ft inside {MSD_T_FLASH, MSD_T_PROGRAM_RAM, MSD_T_EXTERNAL});
    e = t == MSD_T_NONE || (m[2] && ea[0]) || (m[0] && t != MSD_T_DUAL_PORT_RAM)
      || (m[3] && t == MSD_T_FLASH) || (m[3] && t == MSD_T_PROGRAM_RAM && pe && ea[15:0] < pl)
      || (m[1] && !(m[0] || (ea >= MSD_DUAL_PORT_RAM_BIT_BASE && t == MSD_T_DUAL_PORT_RAM)
      || t == MSD_T_SPECIAL_REG || t == MSD_T_EXT_SPECIAL_REG));
    @(posedge sys_clk);
    {fetch_req, fetch_addr, data_req, data_addr} <= {fr, fa, dr, da};
    {data_write, data_word, data_bit_op, data_reg, reg_index, reg_base} <= {m, ri, rb};
    {prot_enable, prot_limit} <= {pe, pl};
    #1;
    chk({fetch_valid, fetch_error, fetch_target, fetch_sysbus}, pf);
    chk({data_valid, data_error, data_target, data_lanes, data_segment, data_page, data_store,
      data_sysbus, data_bit_ok}, pd);
    chk({12'h000, fetch_offset}, {12'h000, pfo});
    chk({12'h000, data_offset}, {12'h000, pdo});
    pf = fr ? {1'b1, fe, fe ? MSD_T_NONE : ft, !fe && ft == MSD_T_EXTERNAL} : 0;
    pd = dr ? {1'b1, e, e ? MSD_T_NONE : t, e ? 2'b00 : m[2] ? 2'b11 : {ea[0], !ea[0]},
      ea[23:14], !e && m[3], !e && t inside {MSD_T_FLASH, MSD_T_PROGRAM_RAM, MSD_T_LOCAL_BUS,
      MSD_T_EXTERNAL}, !e && m[1]} : 0;
    pfo = (fr && !fe) ? ofs(fa, ft) : 20'h00000;
    pdo = (dr && !e) ? ofs(ea, t) : 20'h00000;
    exp_st = exp_st + 16'(dr && !e && m[3] && t == MSD_T_PROGRAM_RAM);
  endtask
  // Corners first, back to back, then seeded random traffic over chosen segments.
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    go(1, 24'he00010, 1, 24'h00f601, 4'h0, 0, 0, 0, 0);
    go(1, 24'h00a000, 1, 24'h00fcff, 4'h2, 0, 0, 0, 0);
    go(1, 24'he00011, 1, 24'h00fd00, 4'h2, 0, 0, 0, 0);
    go(0, 0, 1, 0, 4'h5, 4'hf, MSD_DUAL_PORT_RAM_BASE, 0, 0);
    go(0, 0, 1, 0, 4'h1, 4'h3, MSD_DUAL_PORT_RAM_BASE, 0, 0);
    go(0, 0, 1, 0, 4'h3, 4'h0, MSD_DUAL_PORT_RAM_BASE, 0, 0);
    go(0, 0, 1, 0, 4'h5, 4'hf, 24'h00fdf0, 0, 0);
    go(0, 0, 1, 24'he000ff, 4'h8, 0, 0, 1, 16'h0100);
    go(0, 0, 1, 24'he00100, 4'h8, 0, 0, 1, 16'h0100);
    go(1, 24'hcb0000, 1, 24'hc00000, 4'h8, 0, 0, 0, 0);
    // Mid-run reset wipes the answer due at this very edge; the ports go idle with it.
    @(posedge sys_clk);
    {rst, fetch_req, data_req} <= 3'b100;
    #1;
    chk({fetch_valid, fetch_error, data_valid, data_error, fetch_target, data_target,
      data_lanes, data_store}, 0);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    {pf, pd, pfo, pdo} = '0;
    repeat (1500) begin
      r = $random(seed);
      go(r[0], {segs[r[31:29] % 6], 16'($random(seed))}, r[1], {segs[r[28:26] % 6],
        16'($random(seed))}, r[5:2], r[9:6], rbs[r[11:10] % 3], r[12], r[31:16]);
    end
    repeat (2) go(0, 0, 0, 0, 0, 0, 0, 0, 0);
    @(posedge sys_clk);
    #1;
    chk({16'h0, pram_stores}, {16'h0, exp_st});
    tally_and_finish();
  end
endmodule
